// ==== common/pisw_pkg.sv ====
// Purpose: Shared constants and helpers for the priority interrupt and standby wake block
// Assumes: Single system clock, registers reached over Avalon-MM
// Notes: Behaviour list below, one line per numbered item
//
// Behaviour
// - Three priority levels exist, top above upper above lower, and every request gets one.
// - While serving, a request at the same or a lower level than the one in service waits.
// - Among pending vectors the one with the highest level is granted first.
// - Among pending vectors of equal level the smallest vector address is granted.
// - The 27 sources are merged onto 10 vector addresses.
// - Line zero goes to 00003H and line one to 0000BH, each at top or lower level.
// - 00013H, 0001BH and 00023H serve their listed sources at upper or lower level.
// - 00033H, 0003BH and 00043H serve their serial, converter and timer sources at upper or lower.
// - 0004BH serves port zero, timers four and five and both pulse outputs at upper or lower.
// - Idle stops instructions only, keeps every oscillator, and ends on reset or any enabled interrupt above the level in service.
// - Deep sleep stops instructions and peripherals and turns off all three oscillators.
// - Deep sleep ends on reset, on lines 0,1,2,4,5 at their set level, or on a port zero event.
// - Subclock sleep keeps only the time base, stops ceramic and RC, and holds the crystal as it was.
// - Subclock sleep also ends on a time-base event.

package pisw_pkg;

   // ---------------------------------------------
   // Sizes and register map
   // ---------------------------------------------
   localparam int PISW_NSRC = 27;
   localparam int PISW_NVEC = 10;
   localparam logic [2:0] PISW_OFS_STATUS = 3'h0;
   localparam logic [2:0] PISW_OFS_CLEAR = 3'h1;
   localparam logic [2:0] PISW_OFS_ENABLE = 3'h2;
   localparam logic [2:0] PISW_OFS_LEVEL = 3'h3;
   localparam logic [2:0] PISW_OFS_CTRL = 3'h4;
   localparam logic [2:0] PISW_OFS_SERVICE = 3'h5;
   localparam int PISW_CTL_CER = 2;
   localparam int PISW_CTL_RC = 3;
   localparam int PISW_CTL_XTAL = 4;
   localparam int PISW_CTL_POL = 5;
   localparam logic [12:0] PISW_CTL_RST = 13'h1FFC;
   localparam logic [26:0] PISW_ENABLE_RST = 27'h000_0000;
   localparam logic [9:0] PISW_LEVEL_RST = 10'h000;

   // ---------------------------------------------
   // Levels, modes, sources, vectors
   // ---------------------------------------------
   localparam logic [1:0] PISW_LVL_NONE = 2'h0;
   localparam logic [1:0] PISW_LVL_LOW = 2'h1;
   localparam logic [1:0] PISW_LVL_UP = 2'h2;
   localparam logic [1:0] PISW_LVL_TOP = 2'h3;
   typedef enum logic [1:0] {
      PISW_RUN = 2'h0,
      PISW_IDLE = 2'h1,
      PISW_DEEP = 2'h2,
      PISW_SUB = 2'h3
   } pisw_mode_t;
   localparam int PISW_SRC_BT0 = 7;
   localparam int PISW_SRC_BT1 = 8;
   localparam int PISW_SRC_PORT0 = 23;
   localparam logic [7:0] PISW_VEC_BASE = 8'h03;
   localparam logic [26:0] PISW_VEC_MASK [PISW_NVEC] = '{
      27'h000_0001, 27'h000_0002, 27'h000_001C, 27'h000_01E0, 27'h000_0600,
      27'h000_3800, 27'h001_C000, 27'h00E_0000, 27'h070_0000, 27'h780_0000};

   function automatic logic [7:0] pisw_vec_addr(input logic [3:0] idx);
      return PISW_VEC_BASE + {1'b0, idx, 3'b000};
   endfunction

   function automatic logic [1:0] pisw_vec_lvl(input logic [3:0] idx, input logic hi);
      if (!hi) begin
         return PISW_LVL_LOW;
      end
      return (idx < 4'h2) ? PISW_LVL_TOP : PISW_LVL_UP;
   endfunction

   function automatic logic [1:0] pisw_cur_lvl(input logic [2:0] isv);
      if (isv[2]) begin
         return PISW_LVL_TOP;
      end
      if (isv[1]) begin
         return PISW_LVL_UP;
      end
      return isv[0] ? PISW_LVL_LOW : PISW_LVL_NONE;
   endfunction

endpackage

// ==== tb/pisw_core_model.sv ====
// Purpose: Processor core model that takes offered vectors and returns from service
// Assumes: Acks and returns are one-cycle pulses on sys_clk
// Notes: Acks only while ack_en is high, so the bench can hold an offer open
`timescale 1ns/1ps
`default_nettype none

module pisw_core_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ack_en,
   input wire logic ret_cmd,
   input wire logic irq_req,
   output logic irq_ack,
   output logic irq_ret
);
   // ---------------------------------------------
   // Handshake
   // ---------------------------------------------
   // One pulse per offer; the offer drops the cycle after the ack is taken
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_ack <= 1'b0;
         irq_ret <= 1'b0;
      end else begin
         irq_ack <= ack_en & irq_req & !irq_ack;
         irq_ret <= ret_cmd;
      end
   end
endmodule
`default_nettype wire

// ==== tb/pisw_top_bench.sv ====
// Purpose: Self-checking bench for the interrupt controller and standby wake
// Assumes: One wait state per bus access, events as one-cycle pulses
// Notes: Checks are taken at the falling edge, drives at the rising edge
`timescale 1ns/1ps
`default_nettype none

module pisw_top_bench
   import pisw_pkg::*;
;
   logic sys_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [4:0] avs_address = 5'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic avs_waitrequest, ack_en = 1'b0, ret_cmd = 1'b0, irq_ack, irq_ret, irq_req;
   logic [7:0] ext = 8'h0, irq_vector;
   logic [19:0] periph_event = 20'h0_0000;
   logic [1:0] irq_level;
   logic irq_line, cpu_halt, periph_halt, timebase_halt, oc, orc, ox;
   int n_mismatch = 0, checks = 0;
   localparam int VIDX [20] = '{2, 3, 3, 4, 5, 5, 6, 6, 6, 7, 7, 7, 8, 8, 8, 9, 9, 9, 9, 9};

   always #2.5 sys_clk = ~sys_clk;

   pisw_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ext_irq_zero(ext[0]), .ext_irq_one(ext[1]), .ext_irq_two(ext[2]),
      .ext_irq_three(ext[3]), .ext_irq_four(ext[4]), .ext_irq_five(ext[5]),
      .ext_irq_six(ext[6]), .ext_irq_seven(ext[7]), .periph_event(periph_event),
      .irq_ack(irq_ack), .irq_ret(irq_ret), .irq_req(irq_req), .irq_level(irq_level),
      .irq_vector(irq_vector), .irq_line(irq_line), .cpu_halt(cpu_halt),
      .periph_halt(periph_halt), .timebase_halt(timebase_halt), .osc_ceramic_en(oc),
      .osc_rc_en(orc), .osc_xtal_en(ox));

   pisw_core_model u_core (.sys_clk(sys_clk), .rstn(rstn), .ack_en(ack_en),
      .ret_cmd(ret_cmd), .irq_req(irq_req), .irq_ack(irq_ack), .irq_ret(irq_ret));

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Holds the request until waitrequest is seen low at a falling edge, then drops it after the next rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      logic wt;
      int i;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      for (i = 0; i < 20; i++) begin
         @(negedge sys_clk);
         wt = avs_waitrequest;
         q = avs_readdata;
         @(posedge sys_clk);
         if (wt === 1'b0) break;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (wt !== 1'b0) begin
         n_mismatch++;
         end_of_test();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, exp, q);
   endtask

   task automatic pulse(input logic [19:0] bits);
      @(posedge sys_clk);
      periph_event <= bits;
      @(posedge sys_clk);
      periph_event <= 20'h0_0000;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // Bounded wait: sel 0 for an offer, sel 1 for the core waking
   task automatic wait_for(input logic sel);
      int i;
      checks++;
      for (i = 0; i < 40; i++) begin
         @(negedge sys_clk);
         if (sel ? (cpu_halt === 1'b0) : (irq_req === 1'b1)) break;
         if (i == 39) begin
            n_mismatch++;
            end_of_test();
         end
      end
   endtask

   task automatic ret();
      @(posedge sys_clk);
      ret_cmd <= 1'b1;
      @(posedge sys_clk);
      ret_cmd <= 1'b0;
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_regs();
      rdc("ctrl", 5'h10, 32'h1FFC);
      rdc("enable", 5'h08, 32'h0);
      rdc("unmapped", 5'h18, 32'h0);
      wr(5'h08, 32'h07FF_FFFF);
      rdc("enable", 5'h08, 32'h07FF_FFFF);
      $display("t_regs done");
   endtask

   task automatic t_map();
      int i;
      for (i = 0; i < 20; i++) begin
         pulse(20'h0_0001 << i);
         wait_for(1'b0);
         chk("vector", 32'(PISW_VEC_BASE) + 32'(VIDX[i] * 8), 32'(irq_vector));
         chk("level", 32'h1, 32'(irq_level));
         wr(5'h04, 32'h07FF_FFFF);
      end
      $display("t_map done");
   endtask

   task automatic t_prio();
      pulse(20'h0_1001);
      wait_for(1'b0);
      chk("vector", 32'h13, 32'(irq_vector));
      wr(5'h0C, 32'h0100);
      wait_n(3);
      chk("vector", 32'h43, 32'(irq_vector));
      chk("level", 32'h2, 32'(irq_level));
      wr(5'h0C, 32'h0101);
      ext[0] <= 1'b1;
      wait_n(6);
      chk("vector", 32'h03, 32'(irq_vector));
      chk("level", 32'h3, 32'(irq_level));
      chk("line", 32'h1, 32'(irq_line));
      @(posedge sys_clk);
      ack_en <= 1'b1;
      wait_n(6);
      chk("req", 32'h0, 32'(irq_req));
      @(posedge sys_clk);
      ack_en <= 1'b0;
      ext[0] <= 1'b0;
      wr(5'h04, 32'h1);
      ret();
      wait_for(1'b0);
      chk("vector", 32'h43, 32'(irq_vector));
      @(posedge sys_clk);
      ack_en <= 1'b1;
      wait_n(6);
      chk("req", 32'h0, 32'(irq_req));
      @(posedge sys_clk);
      ack_en <= 1'b0;
      wr(5'h04, 32'h07FF_FFFF);
      ret();
      wait_n(3);
      chk("line", 32'h0, 32'(irq_line));
      rdc("service", 5'h14, 32'h0);
      $display("t_prio done");
   endtask

   task automatic t_sleep();
      wr(5'h10, 32'h1FFE);
      wait_n(0);
      chk("halts", 32'h7, 32'({cpu_halt, periph_halt, timebase_halt}));
      chk("osc", 32'h0, 32'({oc, orc, ox}));
      pulse(20'h0_0002);
      wait_n(4);
      chk("halt", 32'h1, 32'(cpu_halt));
      pulse(20'h0_8000);
      wait_for(1'b1);
      wr(5'h10, 32'h1FFE);
      ext[2] <= 1'b1;
      wait_for(1'b1);
      @(posedge sys_clk);
      ext[2] <= 1'b0;
      // Crystal off before entry, enable bit set by the entry write: the old state must hold
      wr(5'h10, 32'h1FEC);
      wr(5'h10, 32'h1FFF);
      wait_n(0);
      chk("halts", 32'h6, 32'({cpu_halt, periph_halt, timebase_halt}));
      chk("osc", 32'h0, 32'({oc, orc, ox}));
      pulse(20'h0_0004);
      wait_for(1'b1);
      wr(5'h04, 32'h07FF_FFFF);
      wr(5'h10, 32'h1FFD);
      wait_n(0);
      chk("halts", 32'h4, 32'({cpu_halt, periph_halt, timebase_halt}));
      chk("osc", 32'h7, 32'({oc, orc, ox}));
      pulse(20'h0_0001);
      wait_for(1'b1);
      wr(5'h10, 32'h1FFE);
      rstn <= 1'b0;
      wait_n(2);
      chk("halt", 32'h0, 32'(cpu_halt));
      @(posedge sys_clk);
      rstn <= 1'b1;
      $display("t_sleep done");
   endtask

   initial begin
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      t_regs();
      t_map();
      t_prio();
      t_sleep();
      end_of_test();
   end
endmodule
`default_nettype wire

// ==== verilog/pisw_arb.sv ====
// Purpose: Level-then-address arbiter over the ten vectors
// Assumes: Inputs come from registers on sys_clk
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none

module pisw_arb
   import pisw_pkg::*;
(
   input wire logic [9:0] vec_pend,
   input wire logic [9:0] vec_hi,
   input wire logic [1:0] cur_lvl,
   output logic win_valid,
   output logic [3:0] win_idx,
   output logic [1:0] win_lvl
);

   always_comb begin
      logic [1:0] lv;
      lv = PISW_LVL_NONE;
      win_valid = 1'b0;
      win_idx = 4'h0;
      win_lvl = PISW_LVL_NONE;
      // Walking downward with >= lets the smaller address win ties
      for (int v = PISW_NVEC - 1; v >= 0; v--) begin
         lv = pisw_vec_lvl(4'(v), vec_hi[v]);
         if (vec_pend[v] && lv > cur_lvl && lv >= win_lvl) begin
            win_valid = 1'b1;
            win_idx = 4'(v);
            win_lvl = lv;
         end
      end
   end

endmodule
`default_nettype wire

// ==== verilog/pisw_sync.sv ====
// Purpose: Two-stage synchroniser for the external request pins
// Assumes: Pins are asynchronous to sys_clk
// Notes: Only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none

module pisw_sync
   import pisw_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] async_in,
   output logic [7:0] sync_out
);

   typedef struct packed {
      logic [7:0] ff1;
      logic [7:0] ff2;
   } pisw_sync_t;

   pisw_sync_t s;
   pisw_sync_t next_s;

   always_comb begin
      next_s.ff1 = async_in;
      next_s.ff2 = s.ff1;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.ff2;

endmodule
`default_nettype wire

// ==== verilog/pisw_top.sv ====
// Purpose: Nested priority interrupt controller with standby mode control and wake
// Assumes: Core acks and returns are sys_clk pulses; peripheral events are sys_clk pulses
// Notes: One wait state on every Avalon access
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pisw_top
   import pisw_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ext_irq_zero,
   input wire logic ext_irq_one,
   input wire logic ext_irq_two,
   input wire logic ext_irq_three,
   input wire logic ext_irq_four,
   input wire logic ext_irq_five,
   input wire logic ext_irq_six,
   input wire logic ext_irq_seven,
   input wire logic [19:0] periph_event,
   input wire logic irq_ack,
   input wire logic irq_ret,
   output logic irq_req,
   output logic [1:0] irq_level,
   output logic [7:0] irq_vector,
   output logic irq_line,
   output logic cpu_halt,
   output logic periph_halt,
   output logic timebase_halt,
   output logic osc_ceramic_en,
   output logic osc_rc_en,
   output logic osc_xtal_en
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      logic [26:0] status;
      logic [26:0] enable;
      logic [9:0] lvl_sel;
      logic [12:0] ctl;
      pisw_mode_t mode;
      logic xtal_keep;
      logic [2:0] isv;
      logic [7:0] ext_prev;
      logic irq_req;
      logic [1:0] irq_level;
      logic [3:0] irq_idx;
      logic [7:0] irq_vector;
      logic bus_done;
      logic [31:0] rdata;
      logic irq_line;
      logic cpu_halt;
      logic periph_halt;
      logic tb_halt;
      logic cer_en;
      logic rc_en;
      logic xtal_en;
   } pisw_state_t;

   pisw_state_t s;
   pisw_state_t next_s;

   logic [7:0] ext_s;
   logic [7:0] ext_evt;
   logic [26:0] src_evt;
   logic [9:0] vec_pend;
   logic [1:0] cur_lvl;
   logic arb_valid;
   logic [3:0] arb_idx;
   logic [1:0] arb_lvl;
   logic bus_req;
   logic wr_go;
   logic [26:0] clr_mask;
   logic wake_pin;
   logic wake_deep;
   logic [7:0] pol;
   logic [31:0] clr_word;

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (wd & m);
   endfunction

   // ---------------------------------------------
   // Pin capture and source assembly
   // ---------------------------------------------
   pisw_sync u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .async_in({ext_irq_seven, ext_irq_six, ext_irq_five, ext_irq_four,
                 ext_irq_three, ext_irq_two, ext_irq_one, ext_irq_zero}),
      .sync_out(ext_s)
   );

   assign pol = s.ctl[PISW_CTL_POL +: 8];

   // A line raises its event when it enters its configured level
   assign ext_evt = (~(ext_s ^ pol)) & (s.ext_prev ^ pol);

   // Grouped by vector so that each vector owns a contiguous run of bits
   assign src_evt = {
      periph_event[19] | periph_event[18], periph_event[17], periph_event[16],
      periph_event[15], periph_event[14], periph_event[13], periph_event[12],
      periph_event[11], periph_event[10], periph_event[9], periph_event[8],
      periph_event[7], periph_event[6], ext_evt[7], periph_event[5],
      periph_event[4], ext_evt[6], periph_event[3], periph_event[2],
      periph_event[1], ext_evt[5], ext_evt[3], ext_evt[4], periph_event[0],
      ext_evt[2], ext_evt[1], ext_evt[0]};

   // Deep-sleep wake looks at the level, not the edge, so a held line still wakes
   assign wake_pin = |(~(ext_s ^ pol) & 8'h37);
   assign wake_deep = wake_pin | src_evt[PISW_SRC_PORT0];

   always_comb begin
      for (int v = 0; v < PISW_NVEC; v++) begin
         vec_pend[v] = |(s.status & s.enable & PISW_VEC_MASK[v]);
      end
   end

   assign cur_lvl = pisw_cur_lvl(s.isv);

   pisw_arb u_arb (
      .vec_pend(vec_pend),
      .vec_hi(s.lvl_sel),
      .cur_lvl(cur_lvl),
      .win_valid(arb_valid),
      .win_idx(arb_idx),
      .win_lvl(arb_lvl)
   );

   // ---------------------------------------------
   // Bus handshake
   // ---------------------------------------------
   assign bus_req = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~s.bus_done;
   assign wr_go = avs_write & s.bus_done;
   assign clr_word = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
   assign clr_mask = (wr_go && avs_address[4:2] == PISW_OFS_CLEAR) ?
                     clr_word[26:0] : 27'h000_0000;

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      logic [31:0] rd;
      logic [31:0] wv;
      rd = 32'h0000_0000;
      wv = 32'h0000_0000;
      next_s = s;
      next_s.ext_prev = ext_s;
      next_s.bus_done = bus_req & ~s.bus_done;

      case (avs_address[4:2])
         PISW_OFS_STATUS: rd = {5'h00, s.status};
         PISW_OFS_ENABLE: rd = {5'h00, s.enable};
         PISW_OFS_LEVEL: rd = {22'h00_0000, s.lvl_sel};
         PISW_OFS_CTRL: rd = {19'h0_0000, s.ctl[12:2], s.mode};
         PISW_OFS_SERVICE: rd = {22'h00_0000, s.irq_level, s.irq_idx, s.irq_req, s.isv};
         default: rd = 32'h0000_0000;
      endcase
      if (avs_read && !s.bus_done) begin
         next_s.rdata = rd;
      end

      // Set wins over clear, and nothing but a clear drops a pending bit
      next_s.status = (s.status & ~clr_mask) | src_evt;

      if (wr_go) begin
         case (avs_address[4:2])
            PISW_OFS_ENABLE: begin
               wv = be_merge({5'h00, s.enable}, avs_writedata, avs_byteenable);
               next_s.enable = wv[26:0];
            end
            PISW_OFS_LEVEL: begin
               wv = be_merge({22'h00_0000, s.lvl_sel}, avs_writedata, avs_byteenable);
               next_s.lvl_sel = wv[9:0];
            end
            PISW_OFS_CTRL: begin
               wv = be_merge({19'h0_0000, s.ctl}, avs_writedata, avs_byteenable);
               next_s.ctl = {wv[12:2], 2'b00};
               if (s.mode == PISW_RUN && wv[1:0] != 2'b00) begin
                  next_s.mode = pisw_mode_t'(wv[1:0]);
                  next_s.xtal_keep = s.xtal_en;
               end
            end
            default: begin
               wv = 32'h0000_0000;
            end
         endcase
      end

      // In-service stack: a return pops the top level, an ack pushes the granted one
      if (irq_ret) begin
         if (s.isv[2]) begin
            next_s.isv[2] = 1'b0;
         end else if (s.isv[1]) begin
            next_s.isv[1] = 1'b0;
         end else begin
            next_s.isv[0] = 1'b0;
         end
      end
      if (irq_ack && s.irq_req) begin
         case (s.irq_level)
            PISW_LVL_TOP: next_s.isv[2] = 1'b1;
            PISW_LVL_UP: next_s.isv[1] = 1'b1;
            PISW_LVL_LOW: next_s.isv[0] = 1'b1;
            default: next_s.isv = next_s.isv;
         endcase
      end

      // Drop the request on ack so a stale grant is never offered twice
      next_s.irq_req = arb_valid & ~irq_ack;
      next_s.irq_level = arb_lvl;
      next_s.irq_idx = arb_idx;
      next_s.irq_vector = pisw_vec_addr(arb_idx);

      case (s.mode)
         PISW_IDLE: begin
            if (arb_valid) begin
               next_s.mode = PISW_RUN;
            end
         end
         PISW_DEEP: begin
            if (wake_deep) begin
               next_s.mode = PISW_RUN;
            end
         end
         PISW_SUB: begin
            if (wake_deep || src_evt[PISW_SRC_BT0] || src_evt[PISW_SRC_BT1]) begin
               next_s.mode = PISW_RUN;
            end
         end
         default: begin
            next_s.mode = next_s.mode;
         end
      endcase

      next_s.cpu_halt = next_s.mode != PISW_RUN;
      next_s.periph_halt = next_s.mode == PISW_DEEP || next_s.mode == PISW_SUB;
      next_s.tb_halt = next_s.mode == PISW_DEEP;
      next_s.cer_en = next_s.ctl[PISW_CTL_CER] & ~next_s.periph_halt;
      next_s.rc_en = next_s.ctl[PISW_CTL_RC] & ~next_s.periph_halt;
      case (next_s.mode)
         PISW_DEEP: next_s.xtal_en = 1'b0;
         PISW_SUB: next_s.xtal_en = next_s.xtal_keep;
         default: next_s.xtal_en = next_s.ctl[PISW_CTL_XTAL];
      endcase
      next_s.irq_line = |(next_s.status & next_s.enable);
   end

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.enable <= PISW_ENABLE_RST;
         s.lvl_sel <= PISW_LEVEL_RST;
         s.ctl <= PISW_CTL_RST;
         s.mode <= PISW_RUN;
         // Seeded at the reset polarity so no false edge follows reset
         s.ext_prev <= PISW_CTL_RST[PISW_CTL_POL +: 8];
         s.cer_en <= 1'b1;
         s.rc_en <= 1'b1;
         s.xtal_en <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata = s.rdata;
   assign irq_req = s.irq_req;
   assign irq_level = s.irq_level;
   assign irq_vector = s.irq_vector;
   assign irq_line = s.irq_line;
   assign cpu_halt = s.cpu_halt;
   assign periph_halt = s.periph_halt;
   assign timebase_halt = s.tb_halt;
   assign osc_ceramic_en = s.cer_en;
   assign osc_rc_en = s.rc_en;
   assign osc_xtal_en = s.xtal_en;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   logic [1:0] chk_max;
   logic [3:0] chk_idx;

   always_comb begin
      chk_max = PISW_LVL_NONE;
      chk_idx = 4'h0;
      for (int v = 0; v < PISW_NVEC; v++) begin
         if (vec_pend[v] && pisw_vec_lvl(4'(v), s.lvl_sel[v]) > cur_lvl &&
             pisw_vec_lvl(4'(v), s.lvl_sel[v]) > chk_max) begin
            chk_max = pisw_vec_lvl(4'(v), s.lvl_sel[v]);
         end
      end
      for (int v = PISW_NVEC - 1; v >= 0; v--) begin
         if (vec_pend[v] && pisw_vec_lvl(4'(v), s.lvl_sel[v]) == chk_max) begin
            chk_idx = 4'(v);
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_deep_wake;
      s.mode == PISW_DEEP && wake_deep;
   endsequence

   sequence s_back_run;
      s.mode == PISW_RUN && !cpu_halt;
   endsequence

   property p_lvl_legal;
      irq_req |-> irq_level != PISW_LVL_NONE;
   endproperty
   a_lvl_legal: assert property (p_lvl_legal) else $error("request without level");

   property p_refuse;
      irq_req |-> irq_level > cur_lvl;
   endproperty
   a_refuse: assert property (p_refuse) else $error("request not above service level");

   property p_top_level;
      (chk_max != PISW_LVL_NONE && !irq_ack) |=> irq_req && irq_level == $past(chk_max);
   endproperty
   a_top_level: assert property (p_top_level) else $error("highest level not granted");

   property p_small_addr;
      (chk_max != PISW_LVL_NONE && !irq_ack) |=> irq_vector == pisw_vec_addr($past(chk_idx));
   endproperty
   a_small_addr: assert property (p_small_addr) else $error("smallest address not granted");

   property p_vec_zero;
      (s.status[0] && s.enable[0] && s.lvl_sel[0] && s.isv == 3'h0 && !irq_ack)
         |=> irq_req && irq_vector == 8'h03 && irq_level == PISW_LVL_TOP;
   endproperty
   a_vec_zero: assert property (p_vec_zero) else $error("line zero vector wrong");

   property p_no_top_above_one;
      (irq_req && irq_vector > 8'h0B) |-> irq_level != PISW_LVL_TOP;
   endproperty
   a_no_top_above_one: assert property (p_no_top_above_one) else $error("top level misused");

   property p_idle_wake;
      (s.mode == PISW_IDLE && arb_valid) |=> s_back_run ##0 (osc_xtal_en == s.ctl[PISW_CTL_XTAL]);
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle did not end");

   property p_deep_off;
      s.mode == PISW_DEEP |-> periph_halt && timebase_halt && !osc_ceramic_en && !osc_rc_en
                              && !osc_xtal_en;
   endproperty
   a_deep_off: assert property (p_deep_off) else $error("deep sleep left a clock on");

   property p_deep_wake;
      s_deep_wake |=> s_back_run;
   endproperty
   a_deep_wake: assert property (p_deep_wake) else $error("deep sleep did not end");

   property p_sub_hold;
      (s.mode == PISW_SUB && $past(s.mode) == PISW_SUB) |-> $stable(osc_xtal_en) && !timebase_halt
         && !osc_ceramic_en && !osc_rc_en;
   endproperty
   a_sub_hold: assert property (p_sub_hold) else $error("subclock sleep clocks wrong");

   property p_sub_wake;
      (s.mode == PISW_SUB && (src_evt[PISW_SRC_BT0] || src_evt[PISW_SRC_BT1])) |=> s_back_run;
   endproperty
   a_sub_wake: assert property (p_sub_wake) else $error("time base did not wake");

   property p_keep;
      clr_mask == 27'h000_0000 |=> (s.status & $past(s.status)) == $past(s.status);
   endproperty
   a_keep: assert property (p_keep) else $error("pending bit lost");

endmodule
`default_nettype wire
